// ===== rtl/qbs_pkg.sv
// constants shared by the burst-of-four separate-i/o sram port logic
package qbs_pkg;

    // ****************************************************************
    // burst and bus geometry
    // ****************************************************************
    localparam int QBS_BEATS = 4;          // fixed burst length
    localparam int QBS_DATA_W = 36;        // data bits per beat
    localparam int QBS_BYTE_W = 9;         // bits covered by one byte-write mask
    localparam int QBS_ADDR_W = 19;        // burst address width
    localparam int QBS_ARRAY_AW = 4;       // address bits of the modelled storage

    // ****************************************************************
    // pipeline shape, in link clock cycles
    // ****************************************************************
    localparam int QBS_RSH_W = 4;          // read stage shifter length
    localparam int QBS_WSH_W = 3;          // write stage shifter length
    localparam int QBS_SYNC_STAGES = 2;    // flops in every synchroniser

    // ****************************************************************
    // dll bypass mode
    // ****************************************************************
    localparam int QBS_DLL_OFF_MAX_MHZ = 167;  // highest link rate with the dll bypassed

    // beat positions inside a burst
    typedef enum logic [1:0] {
        QBS_BEAT1,
        QBS_BEAT2,
        QBS_BEAT3,
        QBS_BEAT4
    } qbs_beat_t;

endpackage

// ===== rtl/qbs_sync2.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module qbs_sync2 import qbs_pkg::*; #(
    parameter int WIDTH = 1
) (
    // destination clock and reset
    input wire logic clk,
    input wire logic reset,
    // level from the foreign domain, and its safe copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // the first flop is read by the second one only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ===== rtl/qbs_sram_port.sv
// synchronous port logic of a burst-of-four separate-i/o ddr static memory
// Notes on behaviour
// - reads and writes taken on alternating edges
// - every burst is exactly four beats
// - address and selects sampled on true rising
// - beats 1,3 data and masks on true
// - beats 2,4 data and masks on complementary
// - byte masks gate each byte every beat
// - a write spans two input clock cycles
// - read beats 1,3 on complementary, latency 2.5
// - read beats 2,4 on true edges 4,5
// - a read holds the output two cycles
// - separate input and output data ports
// - echo clock pair aligned with read data
// - valid flag high while read data valid
// - valid flag edges aligned with echo clocks
// - echo clocks run free, even when idle
// - read select low registers address, starts read
// - dll bypass gives one-cycle-shorter read latency
`timescale 1ns/100ps
module qbs_sram_port import qbs_pkg::*; #(
    parameter int DATA_W = QBS_DATA_W,
    parameter int BYTE_W = QBS_BYTE_W,
    parameter int ADDR_W = QBS_ADDR_W,
    parameter int ARRAY_AW = QBS_ARRAY_AW
) (
    // core clock and reset
    input wire logic clk,
    input wire logic reset,
    // link input clock pair
    input wire logic k_clk,
    input wire logic k_clk_n,
    // command inputs, sampled on the true clock
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    // write data port with per-byte masks
    input wire logic [DATA_W-1:0] write_data_in,
    input wire logic [DATA_W/BYTE_W-1:0] byte_write_mask_n,
    // dll control pin, low bypasses the dll
    input wire logic dll_enable,
    // read data port
    output logic [DATA_W-1:0] read_data_out,
    output logic read_data_drive_n,
    output logic read_valid_flag,
    // echo clocks
    output logic echo_clock_true,
    output logic echo_clock_comp,
    // core side status
    output logic write_done,
    output logic [ADDR_W-1:0] write_done_addr,
    output logic dll_bypassed
);

    localparam int NBYTES = DATA_W / BYTE_W;
    localparam int DEPTH = 1 << ARRAY_AW;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (DATA_W % BYTE_W != 0) begin : g_bad_byte
        $error("data width must be a whole number of mask lanes");
    end
    if (ARRAY_AW > ADDR_W || ARRAY_AW < 1) begin : g_bad_array
        $error("storage address width must lie between 1 and the address width");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic dll_on;
    logic [QBS_RSH_W-1:0] rsh_reg;
    logic [QBS_WSH_W-1:0] wsh_reg;
    logic rd_accept;
    logic wr_accept;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_addr_buf_reg;
    logic [DATA_W-1:0] mem [DEPTH][QBS_BEATS];
    logic [DATA_W-1:0] wbeat1_reg;
    logic [DATA_W-1:0] wbeat2_reg;
    logic [DATA_W-1:0] wbeat3_reg;
    logic [NBYTES-1:0] wmask1_reg;
    logic [NBYTES-1:0] wmask2_reg;
    logic [NBYTES-1:0] wmask3_reg;
    logic [DATA_W-1:0] commit_word [QBS_BEATS];
    logic [NBYTES-1:0] commit_mask [QBS_BEATS];
    logic [DATA_W-1:0] commit_next [QBS_BEATS];
    logic [DATA_W-1:0] fwd_word [QBS_BEATS];
    logic [NBYTES-1:0] fwd_mask [QBS_BEATS];
    logic [QBS_BEATS-1:0] fwd_ok;
    logic [DATA_W-1:0] rd_next [QBS_BEATS];
    logic [DATA_W-1:0] rd_burst_reg [QBS_BEATS];
    logic load_now;
    logic early_stage;
    logic late_stage;
    logic fwd_hit;
    logic commit_now;
    logic [DATA_W-1:0] q_true_reg;
    logic [DATA_W-1:0] q_comp_reg;
    logic valid_reg;
    logic commit_tog_reg;
    logic [ADDR_W-1:0] commit_addr_reg;
    logic commit_tog_sync;
    logic commit_tog_seen_reg;
    logic write_done_reg;
    logic [ADDR_W-1:0] write_done_addr_reg;
    logic dll_core;

    // ****************************************************************
    // link side: pin synchronisers and command decode
    // ****************************************************************

    // the dll pin is static, but it still passes two flops before use
    qbs_sync2 #(
        .WIDTH(1)
    ) u_dll_sync (
        .clk(k_clk),
        .reset(reset),
        .async_in(dll_enable),
        .sync_out(dll_on)
    );

    // read wins a clash; a select during the second edge of a burst of its own kind is dropped
    assign rd_accept = !read_sel_n && !rsh_reg[0];
    assign wr_accept = !write_sel_n && !wsh_reg[0] && !rd_accept;

    // stage shifters: one bit per pending command, advancing each true edge
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            rsh_reg <= '0;
            wsh_reg <= '0;
        end else begin
            rsh_reg <= {rsh_reg[QBS_RSH_W-2:0], rd_accept};
            wsh_reg <= {wsh_reg[QBS_WSH_W-2:0], wr_accept};
        end
    end

    // addresses are only registered when a select is low
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            rd_addr_reg <= '0;
            wr_addr_reg <= '0;
        end else begin
            if (rd_accept) begin
                rd_addr_reg <= address_in;
            end
            if (wr_accept) begin
                wr_addr_reg <= address_in;
            end
        end
    end

    // ****************************************************************
    // write path
    // ****************************************************************

    // true-edge beats 1 and 3; the address is copied out so that a write
    // command two cycles later cannot disturb the pending commit
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            wbeat1_reg <= '0;
            wbeat3_reg <= '0;
            wmask1_reg <= '0;
            wmask3_reg <= '0;
            wr_addr_buf_reg <= '0;
        end else begin
            if (wsh_reg[0]) begin
                wbeat1_reg <= write_data_in;
                wmask1_reg <= byte_write_mask_n;
                wr_addr_buf_reg <= wr_addr_reg;
            end
            if (wsh_reg[1]) begin
                wbeat3_reg <= write_data_in;
                wmask3_reg <= byte_write_mask_n;
            end
        end
    end

    // complementary-edge beat 2 is stored; beat 4 goes straight to storage
    always_ff @(posedge k_clk_n or posedge reset) begin
        if (reset) begin
            wbeat2_reg <= '0;
            wmask2_reg <= '0;
        end else if (wsh_reg[1]) begin
            wbeat2_reg <= write_data_in;
            wmask2_reg <= byte_write_mask_n;
        end
    end

    assign commit_now = wsh_reg[2];

    // gather the four beats of the burst being committed
    always_comb begin
        commit_word[QBS_BEAT1] = wbeat1_reg;
        commit_word[QBS_BEAT2] = wbeat2_reg;
        commit_word[QBS_BEAT3] = wbeat3_reg;
        commit_word[QBS_BEAT4] = write_data_in;
        commit_mask[QBS_BEAT1] = wmask1_reg;
        commit_mask[QBS_BEAT2] = wmask2_reg;
        commit_mask[QBS_BEAT3] = wmask3_reg;
        commit_mask[QBS_BEAT4] = byte_write_mask_n;
    end

    // ****************************************************************
    // read forwarding
    // ****************************************************************

    // a write is still unfinished while its commit stage is ahead
    assign fwd_hit = (wsh_reg[1] || wsh_reg[2]) && (wr_addr_buf_reg == rd_addr_reg);

    // in bypass mode the load comes one cycle earlier, so beat 4 of a write
    // issued right before the read is not yet here and cannot be forwarded
    always_comb begin
        fwd_word[QBS_BEAT1] = wbeat1_reg;
        fwd_word[QBS_BEAT2] = wbeat2_reg;
        fwd_word[QBS_BEAT3] = wsh_reg[1] ? write_data_in : wbeat3_reg;
        fwd_word[QBS_BEAT4] = '0;
        fwd_mask[QBS_BEAT1] = wmask1_reg;
        fwd_mask[QBS_BEAT2] = wmask2_reg;
        fwd_mask[QBS_BEAT3] = wsh_reg[1] ? byte_write_mask_n : wmask3_reg;
        fwd_mask[QBS_BEAT4] = '1;
        fwd_ok = {1'b0, 1'b1, 1'b1, 1'b1};
    end

    // per beat and per byte lane: merge for commit and for forwarding
    for (genvar bt = 0; bt < QBS_BEATS; bt++) begin : g_beat
        for (genvar ln = 0; ln < NBYTES; ln++) begin : g_lane
            assign commit_next[bt][ln*BYTE_W +: BYTE_W] = commit_mask[bt][ln] ?
                mem[wr_addr_buf_reg[ARRAY_AW-1:0]][bt][ln*BYTE_W +: BYTE_W] :
                commit_word[bt][ln*BYTE_W +: BYTE_W];
            assign rd_next[bt][ln*BYTE_W +: BYTE_W] =
                (fwd_hit && fwd_ok[bt] && !fwd_mask[bt][ln]) ?
                fwd_word[bt][ln*BYTE_W +: BYTE_W] :
                mem[rd_addr_reg[ARRAY_AW-1:0]][bt][ln*BYTE_W +: BYTE_W];
        end
    end

    // storage is written only on the beat-4 edge, with masked bytes kept
    always_ff @(posedge k_clk_n) begin
        if (commit_now) begin
            for (int bt = 0; bt < QBS_BEATS; bt++) begin
                mem[wr_addr_buf_reg[ARRAY_AW-1:0]][bt] <= commit_next[bt];
            end
        end
    end

    // commit event for the core side, address held until the next commit
    always_ff @(posedge k_clk_n or posedge reset) begin
        if (reset) begin
            commit_tog_reg <= 1'b0;
            commit_addr_reg <= '0;
        end else if (commit_now) begin
            commit_tog_reg <= !commit_tog_reg;
            commit_addr_reg <= wr_addr_buf_reg;
        end
    end

    // ****************************************************************
    // read output path
    // ****************************************************************

    // bypassing the dll pulls every read stage one cycle earlier
    assign load_now = dll_on ? rsh_reg[1] : rsh_reg[0];
    assign early_stage = dll_on ? rsh_reg[2] : rsh_reg[1];
    assign late_stage = dll_on ? rsh_reg[3] : rsh_reg[2];

    // the burst is latched whole, so a following read can reuse the address
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            for (int bt = 0; bt < QBS_BEATS; bt++) begin
                rd_burst_reg[bt] <= '0;
            end
        end else if (load_now) begin
            for (int bt = 0; bt < QBS_BEATS; bt++) begin
                rd_burst_reg[bt] <= rd_next[bt];
            end
        end
    end

    // beats 1 and 3 leave on the complementary edges
    always_ff @(posedge k_clk_n or posedge reset) begin
        if (reset) begin
            q_comp_reg <= '0;
        end else if (early_stage) begin
            q_comp_reg <= rd_burst_reg[QBS_BEAT1];
        end else if (late_stage) begin
            q_comp_reg <= rd_burst_reg[QBS_BEAT3];
        end
    end

    // beats 2 and 4 leave on the true edges
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            q_true_reg <= '0;
        end else if (early_stage) begin
            q_true_reg <= rd_burst_reg[QBS_BEAT2];
        end else if (late_stage) begin
            q_true_reg <= rd_burst_reg[QBS_BEAT4];
        end
    end

    // valid spans both stages; it changes on complementary edges only,
    // where the echo pair also switches
    always_ff @(posedge k_clk_n or posedge reset) begin
        if (reset) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= early_stage || late_stage;
        end
    end

    // the half-cycle register pair is steered by the clock level; the mux
    // adds a small skew that the echo clocks share, so capture still works
    assign read_data_out = k_clk ? q_true_reg : q_comp_reg;
    assign read_valid_flag = valid_reg;
    assign read_data_drive_n = !valid_reg;

    // echo clocks are the input pair forwarded, so they never stop
    assign echo_clock_true = k_clk;
    assign echo_clock_comp = k_clk_n;

    // ****************************************************************
    // core side: write completion and mode status
    // ****************************************************************

    // toggle crossing; the address is stable for at least two link cycles,
    // longer than the synchroniser takes, so it is sampled on the event
    qbs_sync2 #(
        .WIDTH(1)
    ) u_commit_sync (
        .clk(clk),
        .reset(reset),
        .async_in(commit_tog_reg),
        .sync_out(commit_tog_sync)
    );

    qbs_sync2 #(
        .WIDTH(1)
    ) u_mode_sync (
        .clk(clk),
        .reset(reset),
        .async_in(dll_on),
        .sync_out(dll_core)
    );

    // one core-clock pulse per committed write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            commit_tog_seen_reg <= 1'b0;
            write_done_reg <= 1'b0;
            write_done_addr_reg <= '0;
        end else begin
            commit_tog_seen_reg <= commit_tog_sync;
            write_done_reg <= commit_tog_sync ^ commit_tog_seen_reg;
            if (commit_tog_sync ^ commit_tog_seen_reg) begin
                write_done_addr_reg <= commit_addr_reg;
            end
        end
    end

    assign write_done = write_done_reg;
    assign write_done_addr = write_done_addr_reg;
    assign dll_bypassed = !dll_core;  // reads high during reset: dll assumed off

endmodule

// ===== bench/qbs_sram_port_monitor.sv
// port checker for the burst-of-four sram port logic
`timescale 1ns/100ps
module qbs_sram_port_monitor import qbs_pkg::*; #(
    parameter int ADDR_W = QBS_ADDR_W
) (
    // clocks and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic k_clk,
    input wire logic k_clk_n,
    // link inputs
    input wire logic read_sel_n,
    input wire logic dll_enable,
    // watched outputs
    input wire logic read_data_drive_n,
    input wire logic read_valid_flag,
    input wire logic echo_clock_true,
    input wire logic echo_clock_comp,
    input wire logic write_done,
    input wire logic [ADDR_W-1:0] write_done_addr,
    input wire logic dll_bypassed
);
    logic rd_taken_reg;
    logic rd_take;
    // a read on the edge right after a taken read is refused, so it must not count
    assign rd_take = !read_sel_n && !rd_taken_reg;
    always_ff @(posedge k_clk or posedge reset) begin
        if (reset) begin
            rd_taken_reg <= 1'b0;
        end else begin
            rd_taken_reg <= rd_take;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_drive_n;
        @(posedge k_clk) disable iff (reset) read_data_drive_n == !read_valid_flag;
    endproperty
    a_drive_n: assert property (p_drive_n) else $error("output enable disagrees with valid");
    property p_echo;
        @(posedge clk) disable iff (reset)
            echo_clock_true == k_clk && echo_clock_comp == k_clk_n;
    endproperty
    a_echo: assert property (p_echo) else $error("echo clocks do not follow link clocks");
    property p_rd_on;
        @(posedge k_clk) disable iff (reset) rd_take && dll_enable |->
            (read_valid_flag == ($past(rd_take, 3) || $past(rd_take, 4))) ##3 read_valid_flag [*2];
    endproperty
    a_rd_on: assert property (p_rd_on) else $error("read burst timing wrong, dll on");
    property p_rd_off;
        @(posedge k_clk) disable iff (reset) rd_take && !dll_enable |-> ##2 read_valid_flag [*2];
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("read burst timing wrong, dll off");
    property p_no_spurious;
        @(posedge k_clk) disable iff (reset) read_valid_flag |->
            (dll_enable ? ($past(rd_take, 3) || $past(rd_take, 4))
                        : ($past(rd_take, 2) || $past(rd_take, 3)));
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("valid without a read");
    property p_done_pulse;
        @(posedge clk) disable iff (reset) write_done |=> !write_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("write done longer than one cycle");
    property p_done_addr;
        @(posedge clk) disable iff (reset) $changed(write_done_addr) |-> write_done;
    endproperty
    a_done_addr: assert property (p_done_addr) else $error("done address moved without done");
    property p_bypass;
        @(posedge clk) disable iff (reset) $changed(dll_bypassed) |-> dll_bypassed == !dll_enable;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass flag against the pin");
    // main scenarios
    c_rd_on: cover property (@(posedge k_clk) disable iff (reset) rd_take && dll_enable);
    c_rd_off: cover property (@(posedge k_clk) disable iff (reset) rd_take && !dll_enable);
    c_back: cover property (@(posedge k_clk) disable iff (reset) read_valid_flag [*4]);
    c_done: cover property (@(posedge clk) disable iff (reset) write_done);
endmodule
bind qbs_sram_port qbs_sram_port_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .reset(reset),
    .k_clk(k_clk), .k_clk_n(k_clk_n), .read_sel_n(read_sel_n), .dll_enable(dll_enable),
    .read_data_drive_n(read_data_drive_n), .read_valid_flag(read_valid_flag),
    .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
    .write_done(write_done), .write_done_addr(write_done_addr), .dll_bypassed(dll_bypassed));

// ===== bench/qbs_host_model.sv
// host memory controller model for the link side of the sram port
`timescale 1ns/100ps
module qbs_host_model import qbs_pkg::*; (
    // link clocks and commands
    output logic k_clk,
    output logic k_clk_n,
    output logic [QBS_ADDR_W-1:0] address_in,
    output logic read_sel_n,
    output logic write_sel_n,
    // write port
    output logic [QBS_DATA_W-1:0] write_data_in,
    output logic [3:0] byte_write_mask_n,
    // read port
    input wire logic [QBS_DATA_W-1:0] read_data_out,
    input wire logic read_valid_flag
);
    // link clock, offset so it never lines up with the core clock
    assign k_clk_n = ~k_clk;
    initial begin
        k_clk = 1'b0;
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        address_in = '0;
        write_data_in = '0;
        byte_write_mask_n = 4'hf;
        #3.3;
        forever #15 k_clk = ~k_clk;
    end
    // command on one true edge, then four beats on alternating edges
    task automatic write_burst(input logic [QBS_ADDR_W-1:0] a, input logic [143:0] d,
        input logic [15:0] m);
        @(posedge k_clk) #7;
        write_sel_n = 1'b0;
        address_in = a;
        @(posedge k_clk) #7;
        write_sel_n = 1'b1;
        for (int b = 0; b < QBS_BEATS; b++) begin
            write_data_in = d[b*QBS_DATA_W +: QBS_DATA_W];
            byte_write_mask_n = m[b*4 +: 4];
            if (b % 2 == 0) @(posedge k_clk);
            else @(posedge k_clk_n);
            #7;
        end
        // beats are over: show the inverse so stale data cannot pass
        write_data_in = ~write_data_in;
        byte_write_mask_n = ~byte_write_mask_n;
    endtask
    // read command, then a look at each beat once it has settled
    task automatic read_burst(input logic [QBS_ADDR_W-1:0] a, input int lat,
        output logic [143:0] q, output logic [3:0] vld);
        @(posedge k_clk) #7;
        read_sel_n = 1'b0;
        address_in = a;
        @(posedge k_clk) #7;
        read_sel_n = 1'b1;
        address_in = ~a;
        repeat (lat) @(posedge k_clk_n);
        for (int b = 0; b < QBS_BEATS; b++) begin
            #10;
            q[b*QBS_DATA_W +: QBS_DATA_W] = read_data_out;
            vld[b] = read_valid_flag;
            if (b % 2 == 0) @(posedge k_clk);
            else @(posedge k_clk_n);
        end
    endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the burst-of-four sram port logic
`timescale 1ns/100ps
module tb_top import qbs_pkg::*; ();
    logic clk, reset, dll_enable, k_clk, k_clk_n, read_sel_n, write_sel_n;
    logic [QBS_ADDR_W-1:0] address_in, write_done_addr, done_addr, last_addr;
    logic [QBS_DATA_W-1:0] write_data_in, read_data_out;
    logic [3:0] byte_write_mask_n;
    logic read_data_drive_n, read_valid_flag, echo_clock_true, echo_clock_comp;
    logic write_done, dll_bypassed;
    logic [31:0] lfsr_reg = 32'h0000000c;
    logic [143:0] exp_mem [16];
    int err_count = 0, checked = 0, done_count = 0, wr_count = 0;
    qbs_host_model host (.k_clk(k_clk), .k_clk_n(k_clk_n), .address_in(address_in),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .write_data_in(write_data_in),
        .byte_write_mask_n(byte_write_mask_n), .read_data_out(read_data_out),
        .read_valid_flag(read_valid_flag));
    qbs_sram_port DUT (.clk(clk), .reset(reset), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .address_in(address_in), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
        .write_data_in(write_data_in), .byte_write_mask_n(byte_write_mask_n),
        .dll_enable(dll_enable), .read_data_out(read_data_out),
        .read_data_drive_n(read_data_drive_n), .read_valid_flag(read_valid_flag),
        .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
        .write_done(write_done), .write_done_addr(write_done_addr), .dll_bypassed(dll_bypassed));
    always #5 clk = ~clk;
    // tally of committed writes seen on the core side
    always @(negedge clk) begin
        if (write_done === 1'b1) begin
            done_count++;
            done_addr = write_done_addr;
        end
    end
    function automatic logic [31:0] rnd();
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return lfsr_reg;
    endfunction
    // lane l covers bits 9l..9l+8 of the burst, gated by mask bit l
    function automatic logic [143:0] merge(input logic [143:0] o, n, input logic [15:0] m);
        for (int l = 0; l < 16; l++) begin
            if (!m[l]) o[l*QBS_BYTE_W +: QBS_BYTE_W] = n[l*QBS_BYTE_W +: QBS_BYTE_W];
        end
        return o;
    endfunction
    task automatic check(input logic [143:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // expectation is updated first, so a read one cycle later sees the new bytes
    task automatic do_write(input logic [3:0] idx, input logic [15:0] m);
        logic [143:0] d;
        logic [31:0] r;
        r = rnd();
        d = {r[15:0], rnd(), rnd(), rnd(), rnd()};
        r = rnd();
        last_addr = {r[14:0], idx};
        exp_mem[idx] = merge(exp_mem[idx], d, m);
        wr_count++;
        host.write_burst(last_addr, d, m);
    endtask
    task automatic do_read(input logic [3:0] idx, input int lat);
        logic [143:0] q;
        logic [3:0] vld;
        logic [31:0] r;
        r = rnd();
        host.read_burst({r[14:0], idx}, lat, q, vld);
        check(q, exp_mem[idx]);
        check(144'(vld), 144'hf);
    endtask
    task automatic set_mode(input logic en);
        @(negedge clk) dll_enable = en;
        for (int n = 0; n < 40 && dll_bypassed !== !en; n++) @(posedge clk);
        check(144'(dll_bypassed), 144'(!en));
        repeat (4) @(posedge k_clk);
    endtask
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
    initial begin
        logic [31:0] r;
        clk = 1'b0;
        reset = 1'b1;
        dll_enable = 1'b1;
        repeat (12) @(negedge clk);
        check(144'({read_valid_flag, read_data_drive_n, write_done}), 144'h2);
        check(144'({dll_bypassed, write_done_addr}), 144'(20'h80000));
        reset = 1'b0;
        repeat (5) @(posedge k_clk);
        // full bursts everywhere, so no read ever meets unwritten storage
        for (int a = 0; a < 16; a++) do_write(a[3:0], 16'h0000);
        // write and read overlapped one cycle apart, half on the written burst
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            fork
                do_write(r[3:0], i == 0 ? 16'hffff : i == 1 ? 16'h0000 : r[23:8]);
                begin
                    @(posedge k_clk);
                    do_read(i % 2 ? r[7:4] : r[3:0], 3);
                end
            join
        end
        // both selects on one edge: the read wins and the write is dropped
        r = rnd();
        fork
            host.write_burst({r[14:0], r[19:16]}, {r, r, r, r, r[15:0]}, 16'h0000);
            do_read(r[19:16], 3);
        join
        // back-to-back reads keep the output busy without a gap
        fork
            do_read(4'h3, 3);
            begin
                repeat (2) @(posedge k_clk);
                do_read(4'hc, 3);
            end
        join
        set_mode(1'b0);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            do_read(r[3:0], 2);
        end
        set_mode(1'b1);
        repeat (10) @(posedge clk);
        check(144'(done_count), 144'(wr_count));
        check(144'(done_addr), 144'(last_addr));
        complete_run();
    end
endmodule
